// File: rtl/cal_map.svh
`ifndef CAL_MAP_SVH
`define CAL_MAP_SVH

// register byte offsets
`define CAL_CTRL_OFF      8'h00
`define CAL_MOTOR_OFF     8'h04
`define CAL_LIMIT_OFF     8'h08
`define CAL_STATUS_OFF    8'h0c
`define CAL_FAULT_OFF     8'h10
`define CAL_ULIM_OFF      8'h14

// ctrl fields
`define CAL_CTRL_ADVMD    7
`define CAL_CTRL_CODE_HI  6
`define CAL_CTRL_CODE_LO  0
`define CAL_CTRL_RST      32'h0000_0000

// motor fields: phase resistance [6:0], bemf constant [14:8]
`define CAL_MOT_R_HI      6
`define CAL_MOT_K_LO      8
`define CAL_MOT_K_HI      14
`define CAL_MOTOR_RST     32'h0000_0000

// limit fields: accel thr [3:0], lock thr [10:8]
`define CAL_LIM_ACC_HI    3
`define CAL_LIM_LCK_LO    8
`define CAL_LIM_LCK_HI    10
`define CAL_LIMIT_RST     32'h0000_0000

// status bits
`define CAL_ST_LOCKED     0
`define CAL_ST_OCP        1
`define CAL_ST_ACCLIM     2
`define CAL_ST_CLOSED     3

// timing
`define CAL_CLK_MHZ       200
`define CAL_TICK_NS       2500
`define CAL_CLK_NS        5
`define CAL_TICK_CYC      (`CAL_TICK_NS / `CAL_CLK_NS)
`define CAL_LOCK_OFF_MS   5
`define CAL_LOCK_OFF_CYC  (`CAL_LOCK_OFF_MS * 1000000 / `CAL_CLK_NS)

`endif

// File: rtl/cal_pkg.sv
package cal_pkg;

	typedef enum logic [3:0] {
		CAL_IDLE  = 4'b0001,
		CAL_ADV   = 4'b0010,
		CAL_LOCK  = 4'b0100,
		CAL_OCP   = 4'b1000
	} cal_state_t;

	// motor side inputs travelling together
	typedef struct packed {
		logic        closed_loop;  // closed loop control active
		logic        zero_cross;   // estimated bemf zero crossing pulse
		logic [8:0]  amp_cmd;      // requested phase voltage amplitude
		logic [8:0]  bemf_amp;     // estimated bemf amplitude
		logic [8:0]  speed;        // electrical speed
		logic [7:0]  current;      // measured low-side current
		logic        oc_trip;      // phase-to-phase overcurrent signal
	} cal_motor_in_t;

	// drive side outputs
	typedef struct packed {
		logic        commutate;    // advance drive state pulse
		logic        drive_en;     // phases driven, else high impedance
		logic [8:0]  amp;          // limited voltage amplitude
	} cal_drive_out_t;

endpackage : cal_pkg

// File: rtl/cal_adv_timer.sv
`timescale 1ns/10ps
`include "cal_map.svh"

// advance counter at 2.5 us resolution, started at each closed-loop zero cross outside lock and overcurrent
module cal_adv_timer
	import cal_pkg::*;
#(
	parameter int TICK_CYC = `CAL_TICK_CYC
) (
	input  wire logic        pclk,      // clock
	input  wire logic        presetn,   // async reset, low
	input  wire logic        start,     // zero cross pulse
	input  wire logic        abort,     // cancel pending advance
	input  wire logic [15:0] ticks,     // advance length in ticks
	output logic             expire     // one-cycle commutate pulse
);
	logic [8:0]  div_cnt;
	logic [15:0] tick_cnt;
	logic        busy;
	wire         tick = (div_cnt == 9'(TICK_CYC - 1));
	wire         done = busy && (tick_cnt == 16'h0000);

	// tick divider restarted at each start pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			div_cnt <= 9'h000;
		else if (start || tick)
			div_cnt <= 9'h000;
		else
			div_cnt <= div_cnt + 9'h001;
	end

	// countdown of advance ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy     <= 1'b0;
			tick_cnt <= 16'h0000;
			expire   <= 1'b0;
		end else begin
			expire <= 1'b0;
			if (abort) begin
				busy <= 1'b0;
			end else if (start) begin
				busy     <= 1'b1; // [RULE_14]
				tick_cnt <= ticks;
			end else if (done) begin
				busy   <= 1'b0;
				expire <= 1'b1; // [RULE_14]
			end else if (busy && tick) begin
				tick_cnt <= tick_cnt - 16'h0001;
			end
		end
	end
endmodule : cal_adv_timer

// File: rtl/cal_top.sv
// Behaviour
// [RULE_01] drive applied ahead of estimated bemf
// [RULE_02] mode bit: 0 fixed, 1 scaled advance
// [RULE_03] fixed mode keeps advance equal setting
// [RULE_04] scaled mode: setting times (u-bemf)/u
// [RULE_05] setting is 2.5us times mantissa shifted
// [RULE_06] amplitude capped at i*r plus speed*k
// [RULE_07] accel limit from 4-bit software field
// [RULE_08] accel limit keeps driving, no fault
// [RULE_09] accel limit only in closed loop
// [RULE_10] lock current trip stops drive, lock
// [RULE_11] overcurrent stops drive, auto resumes
// [RULE_12] overcurrent protection always on, fixed
// [RULE_13] 3-bit lock threshold, hi-z, flag, retry
// [RULE_14] advance counter in 2.5us ticks
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "cal_map.svh"

module cal_top
	import cal_pkg::*;
#(
	parameter int LOCK_OFF_CYC = `CAL_LOCK_OFF_CYC,
	parameter int TICK_CYC     = `CAL_TICK_CYC
) (
	input  wire logic          pclk,     // clock 200 MHz
	input  wire logic          presetn,  // async reset, low
	input  wire logic          psel,     // apb select
	input  wire logic          penable,  // apb enable
	input  wire logic          pwrite,   // apb direction
	input  wire logic [7:0]    paddr,    // apb byte address
	input  wire logic [31:0]   pwdata,   // apb write data
	output logic      [31:0]   prdata,   // apb read data
	output logic               pready,   // apb ready
	output logic               pslverr,  // apb error
	input  wire cal_motor_in_t motor_in, // estimator and sense
	output cal_drive_out_t     drive_out // drive commands
);
	// fixed overcurrent trip level, not programmable
	localparam logic [7:0] OCP_LEVEL = 8'hf0;

	logic [31:0] ctrl_reg;
	logic [31:0] motor_reg;
	logic [31:0] limit_reg;
	logic        motor_locked_flag;
	logic        ocp_seen;
	logic        acc_active;
	logic [31:0] lock_cnt;
	logic [15:0] adv_ticks;
	logic [8:0]  amp_q;
	logic        zc_q;
	cal_state_t  state;
	cal_state_t  next_state;
	logic        expire;

	// apb decode
	wire acc      = psel && penable;
	wire wr       = acc && pwrite;
	wire sel_ctrl = (paddr == `CAL_CTRL_OFF);
	wire sel_mot  = (paddr == `CAL_MOTOR_OFF);
	wire sel_lim  = (paddr == `CAL_LIMIT_OFF);
	wire sel_st   = (paddr == `CAL_STATUS_OFF);
	wire sel_flt  = (paddr == `CAL_FAULT_OFF);
	wire sel_ul   = (paddr == `CAL_ULIM_OFF);
	wire mapped   = sel_ctrl | sel_mot | sel_lim | sel_st | sel_flt | sel_ul;

	// configuration fields
	wire       advance_mode_select = ctrl_reg[`CAL_CTRL_ADVMD]; // [RULE_02]
	wire [6:0] advance_time_code =
		ctrl_reg[`CAL_CTRL_CODE_HI:`CAL_CTRL_CODE_LO];
	wire [6:0] phase_resistance_setting = motor_reg[`CAL_MOT_R_HI:0];
	wire [6:0] bemf_constant_setting =
		motor_reg[`CAL_MOT_K_HI:`CAL_MOT_K_LO];
	wire [3:0] accel_current_threshold =
		limit_reg[`CAL_LIM_ACC_HI:0]; // [RULE_07]
	wire [2:0] lock_current_threshold =
		limit_reg[`CAL_LIM_LCK_HI:`CAL_LIM_LCK_LO]; // [RULE_13]

	// setting time in 2.5 us ticks: mantissa shifted by exponent
	function automatic logic [15:0] setting_ticks(input logic [6:0] code);
		setting_ticks = 16'({12'h000, code[3:0]} << code[6:4]); // [RULE_05]
	endfunction : setting_ticks

	// scale ticks by (u - bemf) / u, zero when bemf reaches u
	function automatic logic [15:0] scale_ticks(
		input logic [15:0] t,
		input logic [8:0]  u,
		input logic [8:0]  e
	);
		logic [24:0] num;
		num = 25'h0000000;
		if (u == 9'h000 || e >= u)
			scale_ticks = 16'h0000;
		else begin
			num = 25'(t) * 25'(u - e);
			scale_ticks = 16'(num / 25'(u));
		end
	endfunction : scale_ticks

	// lock threshold mapped from 3-bit code onto current scale
	function automatic logic [7:0] lock_level(input logic [2:0] c);
		lock_level = {c, 5'h1f};
	endfunction : lock_level

	// advance length from the selected mode
	wire [15:0] base_ticks = setting_ticks(advance_time_code);
	wire [15:0] scaled_ticks = scale_ticks(base_ticks, motor_in.amp_cmd,
		motor_in.bemf_amp); // [RULE_04]
	wire [15:0] sel_ticks = advance_mode_select ? scaled_ticks
		: base_ticks; // [RULE_03]

	// voltage limit: i * r + speed * k, no current sense used
	wire [10:0] ir_term = 11'(accel_current_threshold * phase_resistance_setting);
	wire [15:0] sk_term = 16'(motor_in.speed * bemf_constant_setting);
	wire [16:0] u_limit = 17'(ir_term) + 17'(sk_term); // [RULE_06]
	wire        lim_hit = motor_in.closed_loop &&
		(17'(motor_in.amp_cmd) > u_limit); // [RULE_09]
	wire [8:0]  amp_lim = lim_hit ? u_limit[8:0] : motor_in.amp_cmd;

	// protection triggers; overcurrent has no enable
	wire lock_trip = motor_in.current > lock_level(lock_current_threshold);
	wire oc_now = motor_in.oc_trip ||
		(motor_in.current >= OCP_LEVEL); // [RULE_12]
	wire lock_done = (lock_cnt == 32'(LOCK_OFF_CYC - 1));

	// apb answers in the access cycle, unmapped reports error
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;

	// software writable registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg  <= `CAL_CTRL_RST;
			motor_reg <= `CAL_MOTOR_RST;
			limit_reg <= `CAL_LIMIT_RST;
		end else if (wr) begin
			if (sel_ctrl)
				ctrl_reg <= pwdata & 32'h0000_00ff;
			if (sel_mot)
				motor_reg <= pwdata & 32'h0000_7f7f;
			if (sel_lim)
				limit_reg <= pwdata & 32'h0000_070f;
		end
	end

	// read data registered at the end of the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			prdata <= 32'h0000_0000;
			if (sel_ctrl)
				prdata <= ctrl_reg;
			if (sel_mot)
				prdata <= motor_reg;
			if (sel_lim)
				prdata <= limit_reg;
			if (sel_st)
				prdata <= {28'h0000000, motor_in.closed_loop, acc_active,
					state == CAL_OCP, motor_locked_flag};
			if (sel_flt)
				prdata <= {30'h00000000, ocp_seen, motor_locked_flag};
			if (sel_ul)
				prdata <= {15'h0000, u_limit};
		end
	end

	// protection state machine
	always_comb begin
		next_state = state;
		unique case (state)
			CAL_IDLE, CAL_ADV: begin
				if (oc_now)
					next_state = CAL_OCP; // [RULE_11]
				else if (lock_trip)
					next_state = CAL_LOCK; // [RULE_10]
				else if (motor_in.zero_cross && motor_in.closed_loop)
					next_state = CAL_ADV;
				else if (expire)
					next_state = CAL_IDLE;
			end
			CAL_LOCK: begin
				if (lock_done)
					next_state = CAL_IDLE; // [RULE_13]
			end
			CAL_OCP: begin
				if (!oc_now)
					next_state = CAL_IDLE; // [RULE_11]
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= CAL_IDLE;
		else
			state <= next_state;
	end

	// lock-off timer runs only in lock state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lock_cnt <= 32'h0000_0000;
		else if (state == CAL_LOCK)
			lock_cnt <= lock_done ? 32'h0000_0000 : lock_cnt + 32'h0000_0001;
		else
			lock_cnt <= 32'h0000_0000;
	end

	// status flags: locked set on trip, cleared at restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motor_locked_flag <= 1'b0;
			ocp_seen          <= 1'b0;
			acc_active        <= 1'b0;
		end else begin
			if (next_state == CAL_LOCK && state != CAL_LOCK)
				motor_locked_flag <= 1'b1; // [RULE_10] [RULE_13]
			else if (state == CAL_LOCK && lock_done)
				motor_locked_flag <= 1'b0;
			if (next_state == CAL_OCP)
				ocp_seen <= 1'b1;
			else if (state == CAL_OCP)
				ocp_seen <= 1'b0;
			acc_active <= lim_hit; // [RULE_08]
		end
	end

	// advance latched at zero cross, amplitude registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adv_ticks <= 16'h0000;
			amp_q     <= 9'h000;
			zc_q      <= 1'b0;
		end else begin
			zc_q  <= motor_in.zero_cross && motor_in.closed_loop &&
				(next_state == CAL_ADV);
			if (motor_in.zero_cross)
				adv_ticks <= sel_ticks;
			amp_q <= amp_lim; // [RULE_06]
		end
	end

	// advance timer: commutation fires when advance expires
	cal_adv_timer #(
		.TICK_CYC (TICK_CYC)
	) u_adv (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (zc_q),
		.abort   (state == CAL_LOCK || state == CAL_OCP),
		.ticks   (adv_ticks),
		.expire  (expire)
	);

	// drive outputs; hi-z on lock or overcurrent
	assign drive_out.commutate = expire; // [RULE_01]
	assign drive_out.drive_en = (state == CAL_IDLE) ||
		(state == CAL_ADV); // [RULE_08] [RULE_10] [RULE_11]
	assign drive_out.amp = drive_out.drive_en ? amp_q : 9'h000;
endmodule : cal_top

// File: bench/cal_top_props.sv
`timescale 1ns/10ps

// watches the top ports for protocol and protection relations
module cal_top_props
	import cal_pkg::*;
(
	input wire logic           pclk,      // clock
	input wire logic           presetn,   // reset, low
	input wire logic           psel,      // select
	input wire logic           penable,   // enable
	input wire logic           pwrite,    // direction
	input wire logic [7:0]     paddr,     // address
	input wire logic [31:0]    pwdata,    // write data
	input wire logic [31:0]    prdata,    // read data
	input wire logic           pready,    // ready
	input wire logic           pslverr,   // error
	input wire cal_motor_in_t  motor_in,  // motor side
	input wire cal_drive_out_t drive_out  // drive side
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// bus answers
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
		else $error("no error on unmapped address");
	a_good_addr: assert property (psel && penable && paddr <= 8'h14
		&& paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("error on mapped address");
	// protection and drive
	a_oc_stop: assert property (motor_in.oc_trip |-> ##[1:2] !drive_out.drive_en)
		else $error("drive kept on overcurrent");
	a_ocp_fixed: assert property (motor_in.current >= 8'hf0
		|-> ##[1:2] !drive_out.drive_en)
		else $error("drive kept at fixed overcurrent level");
	a_comm_pulse: assert property (drive_out.commutate |=> !drive_out.commutate)
		else $error("commutate longer than one cycle");
	a_hiz_amp: assert property (!drive_out.drive_en [*2] |-> drive_out.amp == 9'h000)
		else $error("amplitude while outputs off");
	a_amp_cap: assert property (drive_out.drive_en && $stable(motor_in.amp_cmd)
		|-> drive_out.amp <= motor_in.amp_cmd)
		else $error("amplitude above request");

	c_comm: cover property (drive_out.commutate);
	c_hiz: cover property (!drive_out.drive_en);
	c_err: cover property (pslverr);
endmodule : cal_top_props

// File: bench/cal_motor_model.sv
`timescale 1ns/10ps

// far side: estimator outputs and current sense of the motor
module cal_motor_model
	import cal_pkg::*;
(
	input wire logic      pclk,     // clock
	output cal_motor_in_t motor_in  // sensed motor state
);
	initial motor_in = '0;

	// loop state, requested amplitude, bemf and speed
	task automatic set_run(input logic cl, input logic [8:0] u,
		input logic [8:0] e, input logic [8:0] s);
		@(posedge pclk);
		motor_in.closed_loop <= cl;
		motor_in.amp_cmd <= u;
		motor_in.bemf_amp <= e;
		motor_in.speed <= s;
	endtask : set_run

	// low-side current and phase overcurrent
	task automatic set_cur(input logic [7:0] c, input logic oc);
		@(posedge pclk);
		motor_in.current <= c;
		motor_in.oc_trip <= oc;
	endtask : set_cur

	// one-cycle zero crossing
	task automatic zc;
		@(posedge pclk);
		motor_in.zero_cross <= 1'b1;
		@(posedge pclk);
		motor_in.zero_cross <= 1'b0;
	endtask : zc
endmodule : cal_motor_model

// File: bench/cal_top_tb.sv
`timescale 1ns/10ps
`include "cal_map.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
	err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module cal_top_tb;
	import cal_pkg::*;
	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]     paddr;
	logic [31:0]    pwdata, prdata, r;
	cal_motor_in_t  motor_in;
	cal_drive_out_t drive_out;
	int             err_total = 0;
	int             total_checks = 0;

	cal_top #(.LOCK_OFF_CYC(20), .TICK_CYC(4)) cal_top_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .motor_in(motor_in), .drive_out(drive_out));
	cal_motor_model mot (.pclk(pclk), .motor_in(motor_in));

	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic finish_test;
		if (err_total == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : finish_test

	// one apb transfer, waits for pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask : rd

	task automatic wait_n(input int n);
		repeat (n) @(negedge pclk);
	endtask : wait_n

	task automatic t_regs;
		logic e;
		rd(`CAL_LIMIT_OFF);
		`CHK("limit rst", 32'h0, r)
		wr(`CAL_LIMIT_OFF, 32'h0000_070f);
		wr(`CAL_MOTOR_OFF, 32'h0000_007f);
		rd(`CAL_LIMIT_OFF);
		`CHK("limit", 32'h0000_070f, r)
		apb(1'b0, 8'h20, 32'h0, r, e);
		`CHK("unmapped", 33'h1_0000_0000, {e, r})
	endtask : t_regs

	// zero cross to commutate, in cycles of four per tick
	task automatic t_adv(input logic [7:0] ctl, input int t);
		int n;
		wr(`CAL_CTRL_OFF, {24'h0, ctl});
		mot.zc();
		n = 0;
		do begin @(negedge pclk); n++; end
		while (drive_out.commutate !== 1'b1 && n < 20000);
		`CHK("advance", 1'b1, n >= t * 4 + 1 && n <= t * 4 + 4)
	endtask : t_adv

	task automatic t_accel;
		wr(`CAL_MOTOR_OFF, 32'h0000_010a);
		wr(`CAL_LIMIT_OFF, 32'h0000_0702);
		mot.set_run(1'b1, 9'd100, 9'd0, 9'd30);
		wait_n(4);
		`CHK("amp", 11'h464, {drive_out.drive_en, drive_out.amp, 1'b0})
		rd(`CAL_ULIM_OFF);
		`CHK("ulimit", 32'd50, r)
		rd(`CAL_FAULT_OFF);
		`CHK("fault", 32'h0, r)
		rd(`CAL_STATUS_OFF);
		`CHK("acc status", 4'hc, r[3:0])
		mot.set_run(1'b0, 9'd100, 9'd0, 9'd30);
		wait_n(4);
		`CHK("open amp", 9'd100, drive_out.amp)
	endtask : t_accel

	task automatic t_lock;
		wr(`CAL_LIMIT_OFF, 32'h0000_030f);
		mot.set_run(1'b1, 9'd100, 9'd0, 9'd0);
		mot.set_cur(8'h7f, 1'b0);
		wait_n(4);
		`CHK("below lock", 1'b1, drive_out.drive_en)
		mot.set_cur(8'h80, 1'b0);
		mot.set_cur(8'h10, 1'b0);
		wait_n(1);
		`CHK("locked", 1'b0, drive_out.drive_en)
		rd(`CAL_STATUS_OFF);
		`CHK("lock flag", 1'b1, r[`CAL_ST_LOCKED])
		wait_n(30);
		`CHK("retry", 1'b1, drive_out.drive_en)
		rd(`CAL_STATUS_OFF);
		`CHK("flag clr", 1'b0, r[`CAL_ST_LOCKED])
	endtask : t_lock

	task automatic t_ocp;
		wr(`CAL_LIMIT_OFF, 32'hffff_ffff);
		mot.set_cur(8'h10, 1'b1);
		wait_n(3);
		rd(`CAL_FAULT_OFF);
		`CHK("oc fault", 1'b1, r[1])
		wait_n(40);
		`CHK("oc held", 1'b0, drive_out.drive_en)
		mot.set_cur(8'h10, 1'b0);
		wait_n(4);
		`CHK("oc resume", 1'b1, drive_out.drive_en)
		mot.set_cur(8'hf0, 1'b0);
		wait_n(3);
		`CHK("oc level", 1'b0, drive_out.drive_en)
		mot.set_cur(8'h10, 1'b0);
		wait_n(4);
		`CHK("oc level off", 1'b1, drive_out.drive_en)
	endtask : t_ocp

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		mot.set_run(1'b1, 9'd200, 9'd100, 9'd0);
		t_adv(8'h00, 0);
		t_adv(8'h12, 4);
		t_adv(8'h31, 8);
		t_adv(8'h0f, 15);
		t_adv(8'h98, 8);
		t_adv(8'h92, 2);
		mot.set_run(1'b1, 9'd200, 9'd200, 9'd0);
		t_adv(8'h98, 0);
		t_accel();
		t_lock();
		t_ocp();
		finish_test();
	end

	initial begin
		#400000;
		err_total++;
		finish_test();
	end
endmodule : cal_top_tb

bind cal_top cal_top_props cal_top_props_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .motor_in(motor_in), .drive_out(drive_out));
